/* File: core/ptmr_pkg.sv */
// Constants, field layout and carrier types of the paired 16/32-bit timer.
// Assumes a 32-bit APB master and a 100 MHz instruction clock.
package ptmr_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] EVEN_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ODD_CTRL_OFS   = 8'h04;
  localparam logic [7:0] EVEN_COUNT_OFS = 8'h08;
  localparam logic [7:0] ODD_COUNT_OFS  = 8'h0C;
  localparam logic [7:0] EVEN_PER_OFS   = 8'h10;
  localparam logic [7:0] ODD_PER_OFS    = 8'h14;
  localparam logic [7:0] INT_STAT_OFS   = 8'h18;
  localparam logic [7:0] INT_MASK_OFS   = 8'h1C;

  // ==========================================================================
  // Control field positions
  localparam int RUN_BIT  = 15;
  localparam int SIDL_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_HI    = 5;
  localparam int PS_LO    = 4;
  localparam int PAIR_BIT = 3;
  localparam int CS_BIT   = 1;

  // Implemented bits; everything else reads zero
  localparam logic [15:0] EVEN_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] ODD_CTRL_MASK  = 16'hA072;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] PER_RESET      = 16'hFFFF;

  // Prescale codes and terminal counts
  localparam logic [1:0] PS_DIV1   = 2'h0;
  localparam logic [1:0] PS_DIV8   = 2'h1;
  localparam logic [1:0] PS_DIV64  = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] MAX_DIV1   = 8'h00;
  localparam logic [7:0] MAX_DIV8   = 8'h07;
  localparam logic [7:0] MAX_DIV64  = 8'h3F;
  localparam logic [7:0] MAX_DIV256 = 8'hFF;

  // Interrupt status / mask bits
  localparam int STAT_EVEN = 0;
  localparam int STAT_ODD  = 1;

  // ==========================================================================
  // Decoded control word
  typedef struct packed {
    logic       run;
    logic       sidl;
    logic       gate;
    logic [1:0] ps;
    logic       pair;
    logic       cs;
  } ptmr_ctrl_t;

endpackage

/* File: core/ptmr_top.sv */
// Paired 16-bit timers (even, odd) joinable into one 32-bit timer, APB slave.
// Assumes ref_clk is the internal instruction clock; pins are asynchronous.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Even run bit starts/stops the 32-bit pair or the even timer alone.
// - Stop-in-idle set halts the timer while the device idles.
// - Gate bit gates internal clock counting; ignored with external clock.
// - Prescale codes 00,01,10,11 divide by 1, 8, 64, 256.
// - Pairing bit joins both timers into one 32-bit timer.
// - Clock select one counts external pin rising edges, zero internal clock.
// - In 32-bit mode odd control bits have no effect.
// - Control write while running resets the prescale counter.
// - Only first pair's odd timer drives the converter trigger.
// - Unused control bits ignore writes and read zero.
// - Odd control register has same fields except pairing bit.
// - Odd run bit starts/stops odd 16-bit count when unpaired.
// - Even count is low word, odd count high word, same for period.
// - Even clock/gate drive the pair; 32-bit match sets odd flag.
module ptmr_top
  import ptmr_pkg::*;
#(
  parameter bit FIRST_PAIR = 1'b1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device state and pins
  input  wire logic        idle_mode,
  input  wire logic        external_clock_pin,
  input  wire logic        odd_external_clock_pin,
  input  wire logic        even_gate_pin,
  input  wire logic        odd_gate_pin,
  // Events
  output logic             irq,
  output logic             adc_trigger
);

  // ==========================================================================
  // Declarations
  logic [15:0] even_ctrl_reg;
  logic [15:0] odd_ctrl_reg;
  logic [15:0] cnt_reg [2];
  logic [15:0] per_reg [2];
  logic [1:0]  stat_reg;
  logic [1:0]  mask_reg;
  logic [7:0]  presc_reg [2];
  logic [3:0]  pin_meta_reg;
  logic [3:0]  pin_sync_reg;
  logic [3:0]  pin_prev_reg;
  logic [31:0] prdata_reg;
  logic        trig_reg;

  ptmr_ctrl_t  ctl [2];
  logic        pair_mode;
  logic [1:0]  ext_rise;
  logic [1:0]  gate_lvl;
  logic [1:0]  ev_in;
  logic [1:0]  active;
  logic [1:0]  tick;
  logic [7:0]  presc_max [2];
  logic [1:0]  wr_ctrl;
  logic [1:0]  wr_cnt;
  logic [1:0]  wr_per;
  logic        wr_stat;
  logic        wr_mask;
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [1:0]  match16;
  logic        hit32;
  logic        low_wrap;
  logic        ev_even;
  logic        ev_odd;
  logic [31:0] rd_mux;

  function automatic ptmr_ctrl_t dec_ctrl(input logic [15:0] w);
    ptmr_ctrl_t c;
    c.run  = w[RUN_BIT];
    c.sidl = w[SIDL_BIT];
    c.gate = w[GATE_BIT];
    c.ps   = w[PS_HI:PS_LO];
    c.pair = w[PAIR_BIT];
    c.cs   = w[CS_BIT];
    return c;
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0]  = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // ==========================================================================
  // APB decode
  assign access  = psel & penable;
  assign wr_en   = access & pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= INT_MASK_OFS);
  assign pslverr = access & ~mapped;
  assign wr_ctrl = {wr_en && paddr == ODD_CTRL_OFS,
                    wr_en && paddr == EVEN_CTRL_OFS};
  assign wr_cnt  = {wr_en && paddr == ODD_COUNT_OFS,
                    wr_en && paddr == EVEN_COUNT_OFS};
  assign wr_per  = {wr_en && paddr == ODD_PER_OFS,
                    wr_en && paddr == EVEN_PER_OFS};
  assign wr_stat = wr_en && paddr == INT_STAT_OFS;
  assign wr_mask = wr_en && paddr == INT_MASK_OFS;

  // ==========================================================================
  // Control registers
  // unused bits masked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      even_ctrl_reg <= CTRL_RESET;
      odd_ctrl_reg  <= CTRL_RESET;
    end else begin
      if (wr_ctrl[0])
        even_ctrl_reg <= merge16(even_ctrl_reg, pwdata, pstrb)
                         & EVEN_CTRL_MASK;
      if (wr_ctrl[1])
        odd_ctrl_reg <= merge16(odd_ctrl_reg, pwdata, pstrb)
                        & ODD_CTRL_MASK;
    end
  end

  assign pair_mode = ctl[0].pair;
  assign ctl[0]    = dec_ctrl(even_ctrl_reg);
  assign ctl[1]    = dec_ctrl(odd_ctrl_reg);

  // ==========================================================================
  // Pin synchronisers and edge detect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {odd_gate_pin, even_gate_pin,
                       odd_external_clock_pin, external_clock_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign ext_rise = pin_sync_reg[1:0] & ~pin_prev_reg[1:0];
  assign gate_lvl = pin_sync_reg[3:2];

  // ==========================================================================
  // Prescalers; in pair mode the even one feeds both halves
  for (genvar i = 0; i < 2; i++) begin : g_presc
    assign ev_in[i] = ctl[i].cs ? ext_rise[i]
                                : (ctl[i].gate ? gate_lvl[i] : 1'b1);
    assign active[i] = ctl[i].run & ~(ctl[i].sidl & idle_mode)
                       & ~((i == 1) & pair_mode);

    always_comb begin
      unique case (ctl[i].ps)
        PS_DIV1:   presc_max[i] = MAX_DIV1;
        PS_DIV8:   presc_max[i] = MAX_DIV8;
        PS_DIV64:  presc_max[i] = MAX_DIV64;
        PS_DIV256: presc_max[i] = MAX_DIV256;
      endcase
    end

    assign tick[i] = active[i] & ev_in[i] & (presc_reg[i] == presc_max[i]);

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        presc_reg[i] <= 8'h00;
      end else if (!active[i] || (wr_ctrl[i] && ctl[i].run)) begin
        presc_reg[i] <= 8'h00;
      end else if (ev_in[i]) begin
        presc_reg[i] <= tick[i] ? 8'h00 : presc_reg[i] + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Counters and period registers
  assign match16[0] = cnt_reg[0] == per_reg[0];
  assign match16[1] = cnt_reg[1] == per_reg[1];
  // odd half is the high word
  assign hit32      = {cnt_reg[1], cnt_reg[0]} == {per_reg[1], per_reg[0]};
  assign low_wrap   = cnt_reg[0] == 16'hFFFF;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg[0] <= COUNT_RESET;
    end else if (wr_cnt[0]) begin
      cnt_reg[0] <= merge16(cnt_reg[0], pwdata, pstrb);
    end else if (tick[0]) begin
      if (pair_mode ? hit32 : match16[0])
        cnt_reg[0] <= COUNT_RESET;
      else
        cnt_reg[0] <= cnt_reg[0] + 16'h0001;
    end
  end

  // even tick drives high word in pair
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg[1] <= COUNT_RESET;
    end else if (wr_cnt[1]) begin
      cnt_reg[1] <= merge16(cnt_reg[1], pwdata, pstrb);
    end else if (pair_mode) begin
      if (tick[0] && hit32)
        cnt_reg[1] <= COUNT_RESET;
      else if (tick[0] && low_wrap)
        cnt_reg[1] <= cnt_reg[1] + 16'h0001;
    end else if (tick[1]) begin
      cnt_reg[1] <= match16[1] ? COUNT_RESET : cnt_reg[1] + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      per_reg[0] <= PER_RESET;
      per_reg[1] <= PER_RESET;
    end else begin
      if (wr_per[0]) per_reg[0] <= merge16(per_reg[0], pwdata, pstrb);
      if (wr_per[1]) per_reg[1] <= merge16(per_reg[1], pwdata, pstrb);
    end
  end

  // ==========================================================================
  // Events, interrupt and converter trigger
  assign ev_even = ~pair_mode & tick[0] & match16[0];
  // 32-bit match raises the odd flag
  assign ev_odd  = pair_mode ? (tick[0] & hit32) : (tick[1] & match16[1]);

  // Set wins over write-one-to-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg[STAT_EVEN] <= ev_even |
        (stat_reg[STAT_EVEN] & ~(wr_stat & pwdata[STAT_EVEN] & pstrb[0]));
      stat_reg[STAT_ODD]  <= ev_odd |
        (stat_reg[STAT_ODD] & ~(wr_stat & pwdata[STAT_ODD] & pstrb[0]));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      mask_reg <= 2'h0;
    else if (wr_mask && pstrb[0])
      mask_reg <= pwdata[1:0];
  end

  assign irq = |(stat_reg & mask_reg);

  // trigger only from first pair odd
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      trig_reg <= 1'b0;
    else
      trig_reg <= FIRST_PAIR & ev_odd;
  end

  assign adc_trigger = trig_reg;

  // ==========================================================================
  // Read data, captured in the setup cycle so it is a flop in access
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      EVEN_CTRL_OFS:  rd_mux[15:0] = even_ctrl_reg;
      ODD_CTRL_OFS:   rd_mux[15:0] = odd_ctrl_reg;
      EVEN_COUNT_OFS: rd_mux[15:0] = cnt_reg[0];
      ODD_COUNT_OFS:  rd_mux[15:0] = cnt_reg[1];
      EVEN_PER_OFS:   rd_mux[15:0] = per_reg[0];
      ODD_PER_OFS:    rd_mux[15:0] = per_reg[1];
      INT_STAT_OFS:   rd_mux[1:0]  = stat_reg;
      INT_MASK_OFS:   rd_mux[1:0]  = mask_reg;
      default:        rd_mux       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_reg <= rd_mux;
  end

  assign prdata = prdata_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_quiet7;
    !tick[0] [*7];
  endsequence

  sequence s_div8_tick;
    tick[0] && ctl[0].ps == PS_DIV8 && !wr_ctrl[0];
  endsequence

  property p_even_stopped;
    (!ctl[0].run && !wr_cnt[0]) |=> $stable(cnt_reg[0]);
  endproperty
  a_even_stopped: assert property (p_even_stopped)
    else $error("even count moved while stopped");

  property p_idle_halt;
    (ctl[0].sidl && idle_mode) |-> !tick[0];
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("even timer ticked in idle");

  property p_gate_ignored;
    (ctl[0].cs && !ext_rise[0]) |-> !ev_in[0];
  endproperty
  a_gate_ignored: assert property (p_gate_ignored)
    else $error("gate level counted with external clock");

  property p_div8_gap;
    s_div8_tick |=> s_quiet7 or (##[0:6] wr_ctrl[0]);
  endproperty
  a_div8_gap: assert property (p_div8_gap)
    else $error("prescale 1:8 ticked too early");

  property p_pair_carry;
    (pair_mode && tick[0] && low_wrap && !hit32 && !wr_cnt[1])
      |=> cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001;
  endproperty
  a_pair_carry: assert property (p_pair_carry)
    else $error("high word missed carry");

  property p_odd_ignored;
    pair_mode |-> !tick[1] && !ev_even;
  endproperty
  a_odd_ignored: assert property (p_odd_ignored)
    else $error("odd control active in pair mode");

  property p_presc_reset;
    (wr_ctrl[0] && ctl[0].run) |=> presc_reg[0] == 8'h00;
  endproperty
  a_presc_reset: assert property (p_presc_reset)
    else $error("prescaler kept count after control write");

  property p_trigger;
    adc_trigger |-> FIRST_PAIR && $past(ev_odd);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("converter trigger without odd match");

  property p_unused_zero;
    ((even_ctrl_reg & ~EVEN_CTRL_MASK) == 16'h0000)
      && ((odd_ctrl_reg & ~ODD_CTRL_MASK) == 16'h0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bit set");

  property p_odd_stopped;
    (!pair_mode && !ctl[1].run && !wr_cnt[1]) |=> $stable(cnt_reg[1]);
  endproperty
  a_odd_stopped: assert property (p_odd_stopped)
    else $error("odd count moved while stopped");

  // Same-cycle count write wins over the clear
  property p_match_flag;
    (ev_odd && !wr_cnt[1])
      |=> stat_reg[STAT_ODD] && cnt_reg[1] == COUNT_RESET;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("period match did not clear and flag");

endmodule // ptmr_top

`default_nettype wire

/* File: core/ptmr_unused.sv */
// Spare source slot of the timer core; holds no logic.
// Assumes nothing of its surroundings.

/* File: sim/ptmr_pin_src.sv */
// Pin source model: external clock bursts and gate levels for the timers.
// Assumes a free-running ref_clk; clock pins stand low outside bursts.
`timescale 1ns/1ps
`default_nettype none
module ptmr_pin_src #(
  parameter int HALF = 4
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Bench requests
  input  wire logic       burst_go,
  input  wire logic       burst_sel,
  input  wire logic [7:0] burst_len,
  input  wire logic [1:0] gate_lvl,
  output logic            burst_busy,
  // Pins
  output logic            external_clock_pin,
  output logic            odd_external_clock_pin,
  output logic            even_gate_pin,
  output logic            odd_gate_pin
);
  logic [8:0] halves_reg;
  logic [7:0] div_reg;
  logic       lvl_reg;
  logic       sel_reg;

  // ==========================================================================
  // Burst generator
  // rising edges on request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halves_reg <= 9'h000;
      div_reg    <= 8'h00;
      lvl_reg    <= 1'b0;
      sel_reg    <= 1'b0;
    end else if (burst_go && halves_reg == 9'h000) begin
      halves_reg <= {burst_len, 1'b0};
      div_reg    <= 8'h00;
      sel_reg    <= burst_sel;
    end else if (halves_reg != 9'h000) begin
      if (div_reg == 8'(HALF - 1)) begin
        div_reg    <= 8'h00;
        lvl_reg    <= ~lvl_reg;
        halves_reg <= halves_reg - 9'h001;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  assign burst_busy = (halves_reg != 9'h000);
  assign external_clock_pin     = lvl_reg & ~sel_reg;
  assign odd_external_clock_pin = lvl_reg & sel_reg;
  assign even_gate_pin = gate_lvl[0];
  assign odd_gate_pin  = gate_lvl[1];
endmodule // ptmr_pin_src
`default_nettype wire

/* File: sim/paired_16_32_bit_timer_test.sv */
// Self-checking bench for the paired timer: APB master and scenarios.
// Assumes the timer core as APB slave and the pin source model beside it.
`timescale 1ns/1ps
`default_nettype none
module paired_16_32_bit_timer_test import ptmr_pkg::*;;
  logic        ref_clk, rst, psel, penable, pwrite, idle_mode;
  logic [7:0]  paddr, burst_len;
  logic [31:0] pwdata, prdata, rd_val;
  logic [3:0]  pstrb;
  logic        pready, pslverr, irq, adc_trigger, rd_err;
  logic        burst_go, burst_sel, burst_busy;
  logic [1:0]  gate_lvl;
  logic        ext_clk, odd_ext_clk, even_gate, odd_gate;
  int          fail_count = 0;
  int          checks = 0;
  int          trig_count = 0;

  ptmr_top #(.FIRST_PAIR(1'b1)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode),
    .external_clock_pin(ext_clk), .odd_external_clock_pin(odd_ext_clk),
    .even_gate_pin(even_gate), .odd_gate_pin(odd_gate), .irq(irq),
    .adc_trigger(adc_trigger));
  ptmr_pin_src u_pins (.ref_clk(ref_clk), .rst(rst), .burst_go(burst_go),
    .burst_sel(burst_sel), .burst_len(burst_len), .gate_lvl(gate_lvl),
    .burst_busy(burst_busy), .external_clock_pin(ext_clk),
    .odd_external_clock_pin(odd_ext_clk), .even_gate_pin(even_gate),
    .odd_gate_pin(odd_gate));

  // ==========================================================================
  // Clock, monitors, closing
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (adc_trigger === 1'b1) trig_count++;

  task automatic finish_test();
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, hi,
                         input string m);
    checks++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0d", $time, m, got);
    end
  endtask

  // ==========================================================================
  // Bus and helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a missing answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd_val, e, m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wait_irq(input int maxc, output int n);
    n = 0;
    while (n < maxc) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (irq === 1'b1) break;
    end
  endtask

  function automatic logic [31:0] ctl(input logic r, s, g,
                                      input logic [1:0] p, input logic t, c);
    ctl = 32'h0;
    ctl[RUN_BIT] = r;
    ctl[SIDL_BIT] = s;
    ctl[GATE_BIT] = g;
    ctl[PS_HI:PS_LO] = p;
    ctl[PAIR_BIT] = t;
    ctl[CS_BIT] = c;
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rdc(EVEN_CTRL_OFS, 32'h0, "even ctrl reset");
    chk({31'h0, rd_err}, 32'h0, "mapped access error");
    rdc(ODD_CTRL_OFS, 32'h0, "odd ctrl reset");
    rdc(EVEN_PER_OFS, 32'hFFFF, "period reset");
    apb(1'b1, 8'h20, 32'hFFFF);
    chk({31'h0, rd_err}, 32'h1, "unmapped write");
    wr(EVEN_CTRL_OFS, 32'hFFFFFFFF);
    rdc(EVEN_CTRL_OFS, 32'hA07A, "even unused bits");
    wr(ODD_CTRL_OFS, 32'hFFFFFFFF);
    rdc(ODD_CTRL_OFS, 32'hA072, "odd fields");
    wr(EVEN_CTRL_OFS, 32'h0);
    wr(ODD_CTRL_OFS, 32'h0);
    wr(EVEN_COUNT_OFS, 32'h0);
    wr(ODD_COUNT_OFS, 32'h0);
  endtask

  task automatic t_mask();
    wr(EVEN_PER_OFS, 32'h3);
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h0, 0, 0));
    cyc(20);
    wr(EVEN_CTRL_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(INT_STAT_OFS, 32'h1, "even flag");
    wr(INT_MASK_OFS, 32'h1);
    cyc(1);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(INT_STAT_OFS, 32'h1);
    cyc(1);
    chk({31'h0, irq}, 32'h0, "cleared irq");
  endtask

  task automatic t_prescale();
    int div [4] = '{1, 8, 64, 256};
    int n, t0;
    t0 = trig_count;
    for (int i = 0; i < 4; i++) begin
      wr(EVEN_COUNT_OFS, 32'h0);
      wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'(i), 0, 0));
      wait_irq(1100, n);
      chk_rng(n, 4 * div[i] - 2, 4 * div[i] + 3, "prescaled period");
      wr(EVEN_CTRL_OFS, 32'h0);
      wr(INT_STAT_OFS, 32'h1);
    end
    chk(32'(trig_count), 32'(t0), "even timer trigger");
  endtask

  task automatic t_ext();
    logic [7:0] ofs [2] = '{EVEN_CTRL_OFS, ODD_CTRL_OFS};
    logic [7:0] cnt [2] = '{EVEN_COUNT_OFS, ODD_COUNT_OFS};
    int n;
    wr(EVEN_PER_OFS, 32'hFFFF);
    for (int i = 0; i < 2; i++) begin
      wr(cnt[i], 32'h0);
      wr(ofs[i], ctl(1, 0, 1, 2'h0, 0, 1));
      burst_sel <= 1'(i);
      burst_len <= 8'h05;
      burst_go  <= 1'b1;
      @(posedge ref_clk);
      burst_go <= 1'b0;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (burst_busy === 1'b1 && n < 200);
      cyc(8);
      wr(ofs[i], 32'h0);
      rdc(cnt[i], 32'h5, "external edges");
    end
  endtask

  task automatic t_gate();
    wr(EVEN_COUNT_OFS, 32'h0);
    wr(EVEN_CTRL_OFS, ctl(1, 0, 1, 2'h0, 0, 0));
    cyc(30);
    rdc(EVEN_COUNT_OFS, 32'h0, "gate closed");
    gate_lvl <= 2'b01;
    cyc(20);
    gate_lvl <= 2'b00;
    cyc(10);
    wr(EVEN_CTRL_OFS, 32'h0);
    apb(1'b0, EVEN_COUNT_OFS, 32'h0);
    chk_rng(rd_val, 17, 23, "gated count");
  endtask

  task automatic t_idle();
    logic [31:0] a;
    wr(EVEN_COUNT_OFS, 32'h0);
    idle_mode <= 1'b1;
    wr(EVEN_CTRL_OFS, ctl(1, 1, 0, 2'h0, 0, 0));
    cyc(20);
    rdc(EVEN_COUNT_OFS, 32'h0, "halt in idle");
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h0, 0, 0));
    cyc(20);
    apb(1'b0, EVEN_COUNT_OFS, 32'h0);
    chk_rng(rd_val, 18, 26, "run in idle");
    idle_mode <= 1'b0;
    wr(EVEN_CTRL_OFS, 32'h0);
    apb(1'b0, EVEN_COUNT_OFS, 32'h0);
    a = rd_val;
    cyc(20);
    rdc(EVEN_COUNT_OFS, a, "stopped count");
  endtask

  task automatic t_psreset();
    wr(EVEN_COUNT_OFS, 32'h0);
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h3, 0, 0));
    cyc(200);
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h3, 0, 0));
    cyc(200);
    rdc(EVEN_COUNT_OFS, 32'h0, "prescaler restarted");
    cyc(80);
    rdc(EVEN_COUNT_OFS, 32'h1, "first tick");
    wr(EVEN_CTRL_OFS, 32'h0);
  endtask

  task automatic t_odd16();
    int n, t0;
    t0 = trig_count;
    wr(INT_MASK_OFS, 32'h3);
    wr(ODD_PER_OFS, 32'h14);
    wr(ODD_COUNT_OFS, 32'h0);
    wr(ODD_CTRL_OFS, ctl(1, 0, 0, 2'h0, 0, 0));
    wait_irq(40, n);
    chk_rng(n, 19, 25, "odd period");
    wr(ODD_CTRL_OFS, 32'h0);
    rdc(INT_STAT_OFS, 32'h2, "odd flag only");
    chk(32'(trig_count), 32'(t0 + 1), "odd trigger");
    wr(INT_STAT_OFS, 32'h3);
  endtask

  task automatic t_pair();
    int n, t0;
    wr(ODD_CTRL_OFS, ctl(1, 1, 1, 2'h3, 0, 1));
    wr(EVEN_PER_OFS, 32'hFFFF);
    wr(ODD_PER_OFS, 32'h1);
    wr(EVEN_COUNT_OFS, 32'hFFF0);
    wr(ODD_COUNT_OFS, 32'h0);
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h0, 1, 0));
    cyc(30);
    wr(EVEN_CTRL_OFS, ctl(0, 0, 0, 2'h0, 1, 0));
    rdc(ODD_COUNT_OFS, 32'h1, "carry to high word");
    apb(1'b0, EVEN_COUNT_OFS, 32'h0);
    chk_rng(rd_val, 14, 22, "low word");
    wr(EVEN_COUNT_OFS, 32'hFFFA);
    t0 = trig_count;
    wr(EVEN_CTRL_OFS, ctl(1, 0, 0, 2'h0, 1, 0));
    wait_irq(20, n);
    chk_rng(n, 5, 10, "32-bit period");
    wr(EVEN_CTRL_OFS, 32'h0);
    rdc(INT_STAT_OFS, 32'h2, "32-bit flag");
    rdc(ODD_COUNT_OFS, 32'h0, "wrapped high word");
    chk(32'(trig_count), 32'(t0 + 1), "32-bit trigger");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, idle_mode, burst_go, burst_sel} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    burst_len = 8'h00;
    gate_lvl = 2'b00;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_mask();
    t_prescale();
    t_ext();
    t_gate();
    t_idle();
    t_psreset();
    t_odd16();
    t_pair();
    finish_test();
  end

  initial begin
    #400000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // paired_16_32_bit_timer_test
`default_nettype wire
